// ==== hw/terec_pkg.sv ====
// terec_pkg: constants and carrier types of the trip, event and waveform recorder
// assumes a 10 MHz pclk and an APB master with 32-bit data
//
// Behaviour
// - trip, start, thermal-reset records, each tagged by kind
// - 64-record store, oldest displaced when full
// - trip record: stamp, cause, volts, currents, unbalance, capacity
// - stored power is a 16-cycle average
// - thermal-reset record snapshots data before reset
// - start record: stamp, peaks, minimum volts, duration
// - start values refreshed each 0.5 s, logged at run
// - unbalance peak tracked from 0.5 s after start
// - running hours, per-cause trip counters, cleared together
// - seven channels captured continuously
// - 16 samples per cycle, 4800 samples per channel
// - trip halts capture and stamps frozen trace
// - auto-restart on trip reset, else explicit restart
// - capture starts at power-up, trace volatile
// - any reset source clears all latched trips together
// - run mode after 5 to 120 s in run band
`default_nettype none
package terec_pkg;
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HALF_S_MS = 500;
  localparam int unsigned HALF_S_CYC = CLK_HZ / 1000 * HALF_S_MS;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned SEC_CYC = CLK_HZ / 1000 * SEC_MS;
  localparam int unsigned HOUR_SEC = 3600;
  localparam logic [6:0] RUN_DLY_MIN = 7'h05;
  localparam logic [6:0] RUN_DLY_MAX = 7'h78;
  localparam logic [6:0] RUN_DLY_RST = 7'h0a;
  // storage
  localparam int unsigned REC_DEPTH = 64;
  localparam int unsigned REC_AW = 6;
  localparam int unsigned REC_W = 128;
  localparam int unsigned CAP_CH = 7;
  localparam int unsigned CAP_DEPTH = 4800;
  localparam int unsigned CAP_AW = 13;
  localparam int unsigned SMP_W = 16;
  localparam int unsigned SMP_PER_CYC = 16;
  localparam int unsigned AVG_CYC = 16;
  localparam int unsigned AVG_SH = 4;
  localparam int unsigned TRIP_KINDS = 8;
  // record kinds
  localparam logic [1:0] KIND_TRIP = 2'h1;
  localparam logic [1:0] KIND_START = 2'h2;
  localparam logic [1:0] KIND_ETR = 2'h3;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
  localparam logic [11:0] OFF_RUN_DLY = 12'h010;
  localparam logic [11:0] OFF_REC0 = 12'h014;
  localparam logic [11:0] OFF_REC1 = 12'h018;
  localparam logic [11:0] OFF_REC2 = 12'h01c;
  localparam logic [11:0] OFF_REC3 = 12'h020;
  localparam logic [11:0] OFF_CAP_ADDR = 12'h024;
  localparam logic [11:0] OFF_CAP_DATA = 12'h028;
  localparam logic [11:0] OFF_STAMP_HI = 12'h02c;
  localparam logic [11:0] OFF_STAMP_LO = 12'h030;
  localparam logic [11:0] OFF_STAT_SEL = 12'h034;
  localparam logic [11:0] OFF_STAT_DATA = 12'h038;
  // control bits
  localparam int unsigned CTRL_AUTO = 0;
  localparam int unsigned CTRL_RESTART = 1;
  localparam int unsigned CTRL_STAT_CLR = 2;
  localparam int unsigned CTRL_POP = 3;
  localparam int unsigned CTRL_TRIP_RST = 4;
  localparam logic CTRL_AUTO_RST = 1'b0;
  // interrupt bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_TRIP = 0;
  localparam int unsigned IRQ_START = 1;
  localparam int unsigned IRQ_ETR = 2;
  localparam int unsigned IRQ_FROZEN = 3;
  // states
  typedef enum logic [1:0] {MOT_OFF, MOT_START, MOT_RUN} terec_mot_type;
  typedef enum logic [0:0] {CAP_RUN, CAP_FROZEN} terec_cap_type;
  // carriers
  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] volt;
    logic [7:0] unb;
    logic [7:0] tcap;
    logic [15:0] pwr;
  } terec_meas_type;
  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] cause;
    logic [47:0] stamp;
    logic [15:0] cur;
    logic [15:0] volt;
    logic [7:0] unb;
    logic [7:0] tcap;
    logic [15:0] aux;
    logic [7:0] pad;
  } terec_rec_type;
endpackage : terec_pkg
`default_nettype wire

// ==== hw/terec_mem.sv ====
// terec_mem: single-clock memory, one write port, registered read port
// assumes no reset; contents are undefined after power-up
`default_nettype none
module terec_mem #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 4800,
  parameter int unsigned AW = 13
) (
  // clock
  input wire logic pclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_ff
);
  logic [W-1:0] mem_ff [D];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata_ff <= mem_ff[raddr];
  end
endmodule : terec_mem
`default_nettype wire

// ==== hw/terec_top.sv ====
// terec_top: event log, trip statistics and waveform capture behind an APB slave
// assumes front-end inputs synchronous to pclk and one-cycle event strobes
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
module terec_top
  import terec_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_S_CYC,
  parameter int unsigned SECOND_CYC = SEC_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // measurement front end
  input wire logic smp_stb,
  input wire logic [CAP_CH-1:0][SMP_W-1:0] smp,
  input wire logic cyc_stb,
  input wire terec_meas_type meas,
  input wire logic [47:0] stamp,
  input wire logic motor_cur_on,
  input wire logic run_band,
  input wire logic trip_evt,
  input wire logic [5:0] trip_cause,
  input wire logic emergency_thermal_reset,
  // resets and commands
  input wire logic trip_reset_in,
  input wire logic cmd_restart,
  // status
  output logic irq_ff,
  output logic capturing_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup, acc_wr, hit, wr_ctrl;
  logic restart_req, stat_clr, pop_req, trip_clr;
  logic [31:0] rd_mux;
  logic auto_ff, tripped_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
  logic [6:0] run_dly_ff, run_sec_ff;
  logic [2:0] cap_ch_ff, stat_sel_ff;
  logic [CAP_AW-1:0] cap_ra_ff, nxt_cap_ra, cap_wp_ff;
  logic [CAP_CH-1:0][SMP_W-1:0] cap_rd;
  logic [47:0] frz_stamp_ff;
  terec_cap_type cap_st_ff, nxt_cap_st;
  terec_mot_type mot_st_ff;
  logic cap_we, run_enter, sec_tick, half_tick, unb_en_ff;
  logic [23:0] sec_cnt_ff;
  logic [22:0] half_cnt_ff;
  logic [15:0] pk_cur_ff, min_volt_ff, dur_ff, hours_ff, pwr_avg_ff;
  logic [7:0] pk_unb_ff, tcap0_ff;
  logic [47:0] stamp0_ff;
  terec_rec_type st_rec_ff, log_rec, rec_q, rec_vis;
  terec_meas_type meas_q_ff;
  logic [11:0] sec_in_hr_ff;
  logic [TRIP_KINDS-1:0][15:0] trip_cnt_ff;
  logic [19:0] pwr_acc_ff;
  logic [3:0] avg_cnt_ff;
  logic log_we, full, pop_ok;
  logic [REC_AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_rd_ptr;
  logic [6:0] rec_cnt_ff;

  // apb: data prepared in setup, so access always completes with no wait
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pready_ff & pwrite;
  assign wr_ctrl = acc_wr && paddr == OFF_CTRL;
  assign restart_req = (wr_ctrl & pwdata[CTRL_RESTART]) | cmd_restart;
  assign stat_clr = wr_ctrl & pwdata[CTRL_STAT_CLR];
  assign pop_req = wr_ctrl & pwdata[CTRL_POP];
  assign trip_clr = (wr_ctrl & pwdata[CTRL_TRIP_RST]) | trip_reset_in;

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      OFF_CTRL: rd_mux[CTRL_AUTO] = auto_ff;
      OFF_STATUS: rd_mux = {21'h0, mot_st_ff, tripped_ff, capturing_ff, rec_cnt_ff};
      OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      OFF_RUN_DLY: rd_mux[6:0] = run_dly_ff;
      OFF_REC0: rd_mux = rec_vis[127:96];
      OFF_REC1: rd_mux = rec_vis[95:64];
      OFF_REC2: rd_mux = rec_vis[63:32];
      OFF_REC3: rd_mux = rec_vis[31:0];
      OFF_CAP_ADDR: rd_mux = {13'h0, cap_ch_ff, 3'h0, cap_ra_ff};
      OFF_CAP_DATA: rd_mux[SMP_W-1:0] = (cap_ch_ff < 3'(CAP_CH)) ? cap_rd[cap_ch_ff] : '0;
      OFF_STAMP_HI: rd_mux[15:0] = frz_stamp_ff[47:32];
      OFF_STAMP_LO: rd_mux = frz_stamp_ff[31:0];
      OFF_STAT_SEL: rd_mux[2:0] = stat_sel_ff;
      OFF_STAT_DATA: rd_mux = {hours_ff, trip_cnt_ff[stat_sel_ff]};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit;
      prdata_ff <= (setup & ~pwrite) ? rd_mux : '0;
    end
  end

  // software-written settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ff <= CTRL_AUTO_RST;
      irq_mask_ff <= '0;
      run_dly_ff <= RUN_DLY_RST;
      cap_ch_ff <= '0;
      cap_ra_ff <= '0;
      stat_sel_ff <= '0;
    end else begin
      if (wr_ctrl) auto_ff <= pwdata[CTRL_AUTO];
      if (acc_wr && paddr == OFF_IRQ_MASK) irq_mask_ff <= pwdata[IRQ_W-1:0];
      if (acc_wr && paddr == OFF_RUN_DLY) begin
        if (pwdata[31:7] != '0 || pwdata[6:0] > RUN_DLY_MAX) run_dly_ff <= RUN_DLY_MAX;
        else if (pwdata[6:0] < RUN_DLY_MIN) run_dly_ff <= RUN_DLY_MIN;
        else run_dly_ff <= pwdata[6:0];
      end
      if (acc_wr && paddr == OFF_CAP_ADDR) cap_ch_ff <= pwdata[18:16];
      cap_ra_ff <= nxt_cap_ra;
      if (acc_wr && paddr == OFF_STAT_SEL) stat_sel_ff <= pwdata[2:0];
    end
  end
  // read address runs ahead so data are ready for the next setup cycle
  assign nxt_cap_ra = (acc_wr && paddr == OFF_CAP_ADDR) ? pwdata[CAP_AW-1:0] : cap_ra_ff;

  // interrupts: set wins over write-one-to-clear
  assign irq_set = {cap_st_ff == CAP_RUN && trip_evt, log_we && log_rec.kind == KIND_ETR,
                    log_we && log_rec.kind == KIND_START, log_we && log_rec.kind == KIND_TRIP};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((acc_wr && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | irq_set;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // latched trip; a new trip in the clearing cycle stays latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tripped_ff <= 1'b0;
    else tripped_ff <= trip_evt | (tripped_ff & ~trip_clr);
  end

  // timebase; second ticks free-run, so run delay has one second of jitter
  assign sec_tick = sec_cnt_ff == 24'(SECOND_CYC - 1);
  assign half_tick = mot_st_ff == MOT_START && half_cnt_ff == 23'(HALF_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_ff <= '0;
      half_cnt_ff <= '0;
    end else begin
      sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 24'h1;
      half_cnt_ff <= (mot_st_ff != MOT_START || half_tick) ? '0 : half_cnt_ff + 23'h1;
    end
  end

  // motor mode
  assign run_enter = mot_st_ff == MOT_START && run_band && run_sec_ff >= run_dly_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mot_st_ff <= MOT_OFF;
      run_sec_ff <= '0;
    end else begin
      unique case (mot_st_ff)
        MOT_OFF: if (motor_cur_on) mot_st_ff <= MOT_START;
        MOT_START: begin
          if (!motor_cur_on) mot_st_ff <= MOT_OFF;
          else if (run_enter) mot_st_ff <= MOT_RUN;
        end
        MOT_RUN: if (!motor_cur_on) mot_st_ff <= MOT_OFF;
      endcase
      if (mot_st_ff != MOT_START || !run_band) run_sec_ff <= '0;
      else if (sec_tick && run_sec_ff != 7'h7f) run_sec_ff <= run_sec_ff + 7'h1;
    end
  end

  // start tracking; the logged record is the last half-second refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pk_cur_ff <= '0;
      min_volt_ff <= '0;
      pk_unb_ff <= '0;
      unb_en_ff <= 1'b0;
      tcap0_ff <= '0;
      dur_ff <= '0;
      stamp0_ff <= '0;
      st_rec_ff <= '0;
    end else if (mot_st_ff == MOT_OFF && motor_cur_on) begin
      pk_cur_ff <= meas.cur;
      min_volt_ff <= meas.volt;
      pk_unb_ff <= '0;
      unb_en_ff <= 1'b0;
      tcap0_ff <= meas.tcap;
      dur_ff <= '0;
      stamp0_ff <= stamp;
      st_rec_ff <= '0;
    end else if (mot_st_ff == MOT_START) begin
      if (meas.cur > pk_cur_ff) pk_cur_ff <= meas.cur;
      if (meas.volt < min_volt_ff) min_volt_ff <= meas.volt;
      if (unb_en_ff && meas.unb > pk_unb_ff) pk_unb_ff <= meas.unb;
      if (sec_tick) dur_ff <= dur_ff + 16'h1;
      if (half_tick) begin
        unb_en_ff <= 1'b1;
        st_rec_ff.kind <= KIND_START;
        st_rec_ff.stamp <= stamp0_ff;
        st_rec_ff.cur <= pk_cur_ff;
        st_rec_ff.volt <= min_volt_ff;
        st_rec_ff.unb <= pk_unb_ff;
        st_rec_ff.tcap <= meas.tcap - tcap0_ff;
        st_rec_ff.aux <= dur_ff;
      end
    end
  end

  // power average over blocks of 16 line cycles; pre-event snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_acc_ff <= '0;
      avg_cnt_ff <= '0;
      pwr_avg_ff <= '0;
      meas_q_ff <= '0;
    end else begin
      meas_q_ff <= meas;
      if (cyc_stb) begin
        avg_cnt_ff <= avg_cnt_ff + 4'h1;
        if (avg_cnt_ff == 4'(AVG_CYC - 1)) begin
          pwr_avg_ff <= 16'((pwr_acc_ff + 20'(meas.pwr)) >> AVG_SH);
          pwr_acc_ff <= '0;
        end else begin
          pwr_acc_ff <= pwr_acc_ff + 20'(meas.pwr);
        end
      end
    end
  end

  // record assembly; trip outranks thermal reset outranks start
  always_comb begin
    log_we = 1'b1;
    log_rec = '0;
    log_rec.stamp = stamp;
    log_rec.cur = meas_q_ff.cur;
    log_rec.volt = meas_q_ff.volt;
    log_rec.unb = meas_q_ff.unb;
    log_rec.tcap = meas_q_ff.tcap;
    log_rec.aux = pwr_avg_ff;
    if (trip_evt) begin
      log_rec.kind = KIND_TRIP;
      log_rec.cause = trip_cause;
    end else if (emergency_thermal_reset) begin
      log_rec.kind = KIND_ETR;
    end else if (run_enter && motor_cur_on) begin
      log_rec = st_rec_ff;
    end else begin
      log_we = 1'b0;
    end
  end

  // record store, first in first out
  assign full = rec_cnt_ff == 7'(REC_DEPTH);
  assign pop_ok = pop_req && rec_cnt_ff != '0;
  // empty store reads as zero rather than a stale entry
  assign rec_vis = (rec_cnt_ff == '0) ? '0 : rec_q;
  assign nxt_rd_ptr = (pop_ok || (log_we && full)) ? rd_ptr_ff + 6'h1 : rd_ptr_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      rec_cnt_ff <= '0;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      if (log_we) wr_ptr_ff <= wr_ptr_ff + 6'h1;
      if (log_we && !full && !pop_ok) rec_cnt_ff <= rec_cnt_ff + 7'h1;
      else if (!log_we && pop_ok) rec_cnt_ff <= rec_cnt_ff - 7'h1;
    end
  end
  terec_mem #(.W(REC_W), .D(REC_DEPTH), .AW(REC_AW)) u_rec (
    .pclk(pclk),
    .we(log_we),
    .waddr(wr_ptr_ff),
    .wdata(log_rec),
    .raddr(nxt_rd_ptr),
    .rdata_ff(rec_q)
  );

  // statistics
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_in_hr_ff <= '0;
      hours_ff <= '0;
    end else if (stat_clr) begin
      sec_in_hr_ff <= '0;
      hours_ff <= '0;
    end else if (sec_tick && mot_st_ff != MOT_OFF) begin
      sec_in_hr_ff <= (sec_in_hr_ff == 12'(HOUR_SEC - 1)) ? '0 : sec_in_hr_ff + 12'h1;
      if (sec_in_hr_ff == 12'(HOUR_SEC - 1)) hours_ff <= hours_ff + 16'h1;
    end
  end
  for (genvar i = 0; i < TRIP_KINDS; i++) begin : g_cnt
    logic bump;
    assign bump = trip_evt && trip_cause[2:0] == 3'(i);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) trip_cnt_ff[i] <= '0;
      else if (stat_clr) trip_cnt_ff[i] <= {15'h0, bump};
      else if (bump) trip_cnt_ff[i] <= trip_cnt_ff[i] + 16'h1;
    end
  end

  // waveform capture; reset enters run, as no trip is held after power-up
  always_comb begin
    nxt_cap_st = cap_st_ff;
    unique case (cap_st_ff)
      CAP_RUN: if (trip_evt) nxt_cap_st = CAP_FROZEN;
      CAP_FROZEN: if ((trip_clr && auto_ff) || restart_req) nxt_cap_st = CAP_RUN;
    endcase
  end
  assign cap_we = cap_st_ff == CAP_RUN && smp_stb && !trip_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_st_ff <= CAP_RUN;
      capturing_ff <= 1'b1;
      cap_wp_ff <= '0;
      frz_stamp_ff <= '0;
    end else begin
      cap_st_ff <= nxt_cap_st;
      capturing_ff <= nxt_cap_st == CAP_RUN;
      if (cap_st_ff == CAP_RUN && trip_evt) frz_stamp_ff <= stamp;
      if (cap_we) cap_wp_ff <= (cap_wp_ff == 13'(CAP_DEPTH - 1)) ? '0 : cap_wp_ff + 13'h1;
    end
  end
  for (genvar c = 0; c < CAP_CH; c++) begin : g_cap
    terec_mem #(.W(SMP_W), .D(CAP_DEPTH), .AW(CAP_AW)) u_mem (
      .pclk(pclk),
      .we(cap_we),
      .waddr(cap_wp_ff),
      .wdata(smp[c]),
      .raddr(nxt_cap_ra),
      .rdata_ff(cap_rd[c])
    );
  end

  // checks
  property p_fifo_bound;
    rec_cnt_ff <= 7'(REC_DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("record count above depth");
  property p_trip_kind;
    trip_evt |-> log_we && log_rec.kind == KIND_TRIP && log_rec.cause == trip_cause;
  endproperty
  a_trip_kind: assert property (p_trip_kind) else $error("trip not logged as trip");
  property p_freeze;
    cap_st_ff == CAP_RUN && trip_evt |=> cap_st_ff == CAP_FROZEN && !capturing_ff && frz_stamp_ff == $past(stamp);
  endproperty
  a_freeze: assert property (p_freeze) else $error("trip did not freeze capture");
  property p_no_write;
    cap_st_ff == CAP_FROZEN |-> !cap_we;
  endproperty
  a_no_write: assert property (p_no_write) else $error("frozen trace written");
  property p_wrap;
    cap_we && cap_wp_ff == 13'(CAP_DEPTH - 1) |=> cap_wp_ff == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("capture pointer did not wrap");
  property p_manual;
    cap_st_ff == CAP_FROZEN && !auto_ff && !restart_req |=> cap_st_ff == CAP_FROZEN;
  endproperty
  a_manual: assert property (p_manual) else $error("capture resumed without restart");
  property p_auto;
    cap_st_ff == CAP_FROZEN && auto_ff && trip_clr |=> cap_st_ff == CAP_RUN && capturing_ff;
  endproperty
  a_auto: assert property (p_auto) else $error("auto restart failed");
  property p_ignore;
    cap_st_ff == CAP_RUN && restart_req && !trip_evt && !smp_stb |=> $stable(cap_wp_ff) && cap_st_ff == CAP_RUN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("restart disturbed running capture");
  property p_unb_hold;
    mot_st_ff == MOT_START && !unb_en_ff |-> pk_unb_ff == '0;
  endproperty
  a_unb_hold: assert property (p_unb_hold) else $error("unbalance tracked too early");
  property p_start_log;
    run_enter && motor_cur_on && !trip_evt && !emergency_thermal_reset |-> log_we && log_rec.kind == KIND_START
      ##1 mot_st_ff == MOT_RUN;
  endproperty
  a_start_log: assert property (p_start_log) else $error("start record not logged at run");
  property p_trip_clear;
    trip_clr && !trip_evt |=> !tripped_ff;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("latched trip not cleared");
  property p_stat_clear;
    stat_clr |=> hours_ff == '0 && sec_in_hr_ff == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("statistics not cleared");
  c_freeze: cover property (cap_st_ff == CAP_RUN && trip_evt ##[1:20] cap_st_ff == CAP_RUN);
  c_start: cover property (mot_st_ff == MOT_START ##1 mot_st_ff == MOT_RUN);
  c_full: cover property (full && log_we);
  c_etr: cover property (emergency_thermal_reset && log_we);
endmodule : terec_top
`default_nettype wire

// ==== tb/terec_front_model.sv ====
// terec_front_model: stand-in for the sampling front end and the host link
// assumes pclk and presetn come from the bench; host commands arrive decoded
`default_nettype none
module terec_front_model
  import terec_pkg::*;
#(
  parameter logic [47:0] STAMP = 48'h1703_1512_3045
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  // front end
  output logic smp_stb,
  output logic [CAP_CH-1:0][SMP_W-1:0] smp,
  output logic cyc_stb,
  output terec_meas_type meas,
  output logic [47:0] stamp,
  output logic cmd_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] div_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end
  // four clocks a sample keeps the run short
  assign smp_stb = div_ff[1:0] == 2'h3;
  assign cyc_stb = div_ff == 6'h3f;
  assign smp = {CAP_CH{{10'h000, div_ff}}};
  assign meas = {4{{10'h000, div_ff}}};
  assign stamp = STAMP;
  // any other code is not a restart
  assign cmd_restart = cmd_valid && cmd_code == 8'h0d;
endmodule : terec_front_model
`default_nettype wire

// ==== tb/test_trip_event_waveform_recorder.sv ====
// test_trip_event_waveform_recorder: register-level tests of the recorder
// assumes zero-wait apb answers and short half-second and second counts
`default_nettype none
module test_trip_event_waveform_recorder
  import terec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] STAMP = 48'h1703_1512_3045;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata_ff, q;
  logic pready_ff, pslverr_ff, irq_ff, capturing_ff, err, smp_stb, cyc_stb, cmd_restart;
  logic [3:0] ev = 4'h0;
  logic motor_cur_on = 1'b0, run_band = 1'b0;
  logic [5:0] cause = 6'h0b;
  logic [7:0] code = 8'h0d;
  logic [CAP_CH-1:0][SMP_W-1:0] smp;
  terec_meas_type meas;
  logic [47:0] stamp;
  int num_errors = 0, tests_run = 0, cyc = 0, i;
  terec_front_model #(.STAMP(STAMP)) i_terec_front_model (.pclk(pclk), .presetn(presetn),
    .cmd_valid(ev[3]), .cmd_code(code), .smp_stb(smp_stb), .smp(smp), .cyc_stb(cyc_stb),
    .meas(meas), .stamp(stamp), .cmd_restart(cmd_restart));
  terec_top #(.HALF_CYC(50), .SECOND_CYC(100)) i_terec_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .smp_stb(smp_stb),
    .smp(smp), .cyc_stb(cyc_stb), .meas(meas), .stamp(stamp), .motor_cur_on(motor_cur_on),
    .run_band(run_band), .trip_evt(ev[0]), .trip_cause(cause), .emergency_thermal_reset(ev[1]),
    .trip_reset_in(ev[2]), .cmd_restart(cmd_restart), .irq_ff(irq_ff), .capturing_ff(capturing_ff));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // the cycle ceiling cuts a hung handshake short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    q = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one-cycle strobe: bit0 trip, bit1 thermal reset, bit2 trip reset, bit3 host command
  task automatic pulse(input logic [3:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 4'h0;
  endtask : pulse
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0080);
    apb(0, OFF_RUN_DLY, 0); chk(q, 32'h0000_000a);
    apb(1, OFF_RUN_DLY, 32'h0000_00c8); apb(0, OFF_RUN_DLY, 0); chk(q, 32'h0000_0078);
    apb(0, 12'hffc, 0); chk({31'h0, err}, 32'h0000_0001);
    apb(1, OFF_IRQ_MASK, 32'h0000_000f);
    pulse(4'h1);
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0101);
    chk({31'h0, capturing_ff}, 32'h0000_0000);
    // samples 0 and 1 after reset carry front-end counts 3 and 7
    apb(1, OFF_CAP_ADDR, 32'h0006_0001); apb(0, OFF_CAP_ADDR, 0); chk(q, 32'h0006_0001);
    apb(0, OFF_CAP_DATA, 0); chk(q, 32'h0000_0007);
    apb(1, OFF_CAP_ADDR, 32'h0000_0000); apb(0, OFF_CAP_DATA, 0); chk(q, 32'h0000_0003);
    apb(1, OFF_CAP_ADDR, 32'h0007_0000); apb(0, OFF_CAP_DATA, 0); chk(q, 32'h0000_0000);
    chk({31'h0, irq_ff}, 32'h0000_0001);
    apb(0, OFF_REC0, 0); chk(q, {2'h1, 6'h0b, STAMP[47:24]});
    apb(0, OFF_STAMP_HI, 0); chk(q, {16'h0000, STAMP[47:32]});
    apb(1, OFF_IRQ_STAT, 32'h0000_000f); apb(0, OFF_IRQ_STAT, 0); chk(q, 32'h0000_0000);
    chk({31'h0, irq_ff}, 32'h0000_0000);
    pulse(4'h4); apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0001);
    code <= 8'h0c;
    pulse(4'h8); apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0001);
    code <= 8'h0d;
    pulse(4'h8); apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0081);
    pulse(4'h8); apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0081);
    cause <= 6'h05;
    apb(1, OFF_CTRL, 32'h0000_0001); pulse(4'h1); pulse(4'h4);
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0082);
    chk({31'h0, capturing_ff}, 32'h0000_0001);
    apb(1, OFF_STAT_SEL, 32'h0000_0003); apb(0, OFF_STAT_DATA, 0); chk(q, 32'h0000_0001);
    apb(1, OFF_STAT_SEL, 32'h0000_0005); apb(0, OFF_STAT_DATA, 0); chk(q, 32'h0000_0001);
    apb(1, OFF_CTRL, 32'h0000_0005); apb(0, OFF_STAT_DATA, 0); chk(q, 32'h0000_0000);
    pulse(4'h2); apb(1, OFF_CTRL, 32'h0000_0009); apb(1, OFF_CTRL, 32'h0000_0009);
    apb(0, OFF_REC0, 0); chk({30'h0, q[31:30]}, 32'h0000_0003);
    for (i = 0; i < 66; i++) pulse(4'h2);
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_00c0);
    for (i = 0; i < 65; i++) apb(1, OFF_CTRL, 32'h0000_0009);
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0080);
    apb(0, OFF_REC0, 0); chk(q, 32'h0000_0000);
    apb(1, OFF_RUN_DLY, 32'h0000_0000); apb(0, OFF_RUN_DLY, 0); chk(q, 32'h0000_0005);
    motor_cur_on <= 1'b1;
    run_band <= 1'b1;
    i = 0;
    do begin
      apb(0, OFF_STATUS, 0);
      i++;
    end while (q[10:9] !== 2'h2 && i < 400);
    chk(q, 32'h0000_0481);
    apb(0, OFF_REC0, 0); chk({30'h0, q[31:30]}, 32'h0000_0002);
    // long enough for the capture pointer to wrap
    repeat (19300) @(posedge pclk);
    apb(0, OFF_STATUS, 0); chk(q, 32'h0000_0481);
    complete_run();
  end
endmodule : test_trip_event_waveform_recorder
`default_nettype wire
